/* File: verilog/rst_source_ctl.sv */
// reset source controller: gathers seven sources, holds and releases core
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module rst_source_ctl
   import rstctl_pkg::*;
#(
   parameter int POR_CYCLES = POR_TIMEOUT_CYC,
   parameter int MCD_CYCLES = MCD_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // reset sources
   input wire logic SUPPLY_LOW,
   input wire logic RST_PIN_I,
   input wire logic CONVERT_START_INPUT,
   input wire logic COMPARATOR_OUT,
   input wire logic CLOCK_ALIVE,
   input wire logic WDT_TIMEOUT,
   // reset pin drive (open drain)
   output logic RST_PIN_O,
   output logic RST_PIN_OE,
   // to core
   output logic CORE_RESET,
   output logic CORE_RESET_ASYNC,
   output core_init_s CORE_INIT
);
   typedef struct packed {
      phase_e phase;
      logic [CNT_W-1:0] cnt;
      logic drive_pin;
      logic [6:0] flags;
      logic [6:0] cause;
      logic cmp_arm;
      logic cnv_arm;
      logic [7:0] osc;
      logic [15:0] mcd_cnt;
      logic [7:0] rdata;
   } state_s;

   state_s r;
   state_s next_r;

   // ---------------------------------------------------------------
   // source detection
   // ---------------------------------------------------------------
   logic pin_src;
   logic cmp_src;
   logic cnv_src;
   logic mcd_src;
   logic sw_wr;
   logic por_wr;
   logic por_src;
   logic any_src;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n);
   endfunction : cyc

   // own low drive reads back on the pin; it must not restart the hold
   assign pin_src = ~RST_PIN_I & ~r.drive_pin;
   assign cmp_src = r.cmp_arm & ~COMPARATOR_OUT;
   assign cnv_src = r.cnv_arm & ~CONVERT_START_INPUT;
   assign mcd_src = r.osc[BIT_MCD_EN] & (r.mcd_cnt >= 16'(MCD_CYCLES));
   assign sw_wr = WR && ADDR == ADDR_SOURCE && WDATA[BIT_SW];
   assign por_wr = WR && ADDR == ADDR_SOURCE && WDATA[BIT_POR];
   assign por_src = SUPPLY_LOW | por_wr;
   assign any_src = por_src | pin_src | cnv_src | sw_wr | cmp_src
      | mcd_src | WDT_TIMEOUT;

   // comparator path reaches the core without needing a clock edge
   assign CORE_RESET_ASYNC = cmp_src | ~RESETN;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.rdata = 8'h00;
      // clock monitor: counts cycles with no sign of clock activity
      if (!r.osc[BIT_MCD_EN] || CLOCK_ALIVE) begin
         next_r.mcd_cnt = 16'h0000;
      end else if (r.mcd_cnt < 16'(MCD_CYCLES)) begin
         next_r.mcd_cnt = r.mcd_cnt + 16'h0001;
      end
      if (r.phase == ST_RUN && WR) begin
         if (ADDR == ADDR_SOURCE) begin
            next_r.cmp_arm = WDATA[BIT_CMP];
            next_r.cnv_arm = WDATA[BIT_CNV];
         end else if (ADDR == ADDR_OSC) begin
            next_r.osc = WDATA;
         end
      end
      if (RD) begin
         if (ADDR == ADDR_SOURCE) begin
            next_r.rdata = {1'b0, r.flags};
         end else if (ADDR == ADDR_OSC) begin
            next_r.rdata = r.osc;
         end
      end
      // any live source restarts the hold (only a power source while the pin is driven); later sources add to cause
      if (any_src) begin
         next_r.phase = ST_HOLD;
         if (r.phase == ST_RUN) begin
            next_r.cause = 7'h00;
         end
         if (r.phase == ST_RUN || next_r.cause[BIT_POR] == 1'b0) begin
            next_r.cause[BIT_POR] = por_src;
         end
         next_r.cause[BIT_PIN] = next_r.cause[BIT_PIN] | pin_src;
         next_r.cause[BIT_CNV] = next_r.cause[BIT_CNV] | cnv_src;
         next_r.cause[BIT_SW] = next_r.cause[BIT_SW] | sw_wr;
         next_r.cause[BIT_CMP] = next_r.cause[BIT_CMP] | cmp_src;
         next_r.cause[BIT_MCD] = next_r.cause[BIT_MCD] | mcd_src;
         next_r.cause[BIT_WDT] = next_r.cause[BIT_WDT] | WDT_TIMEOUT;
         if (por_src) begin
            next_r.drive_pin = 1'b1;
            next_r.cnt = cyc(POR_CYCLES);
         end else if (!next_r.drive_pin) begin
            next_r.cnt = cyc(PIN_HOLD_CYC);
         end
      end else begin
         case (r.phase)
            ST_HOLD: begin
               next_r.phase = ST_STRETCH;
            end
            ST_STRETCH: begin
               if (r.cnt > cyc(1)) begin
                  next_r.cnt = r.cnt - cyc(1);
               end else begin
                  next_r.phase = ST_RUN;
                  next_r.drive_pin = 1'b0;
                  next_r.cmp_arm = 1'b0;
                  next_r.cnv_arm = 1'b0;
                  next_r.osc = 8'h00;
                  next_r.mcd_cnt = 16'h0000;
                  if (r.cause[BIT_POR]) begin
                     next_r.flags = 7'h00;
                     next_r.flags[BIT_POR] = 1'b1;
                  end else begin
                     next_r.flags = r.cause;
                  end
               end
            end
            default: begin
               next_r.phase = ST_RUN;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         r <= '{
            phase: ST_HOLD,
            cnt: CNT_W'(PIN_HOLD_CYC),
            drive_pin: 1'b1,
            flags: 7'h02,
            cause: 7'h02,
            cmp_arm: 1'b0,
            cnv_arm: 1'b0,
            osc: 8'h00,
            mcd_cnt: 16'h0000,
            rdata: 8'h00
         };
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign RDATA = r.rdata;
   assign RST_PIN_O = 1'b0;
   assign RST_PIN_OE = r.drive_pin;
   // core halts and loads register reset values while held; memory untouched
   assign CORE_RESET = (r.phase != ST_RUN) | CORE_RESET_ASYNC;
   assign CORE_INIT.port_latch = PORT_LATCH_RESET;
   assign CORE_INIT.pc_load = PC_RESET;
   assign CORE_INIT.clk_sel = OSC_SEL_INT2M;
   assign CORE_INIT.wdt_interval = WDT_INTERVAL_MAX;
   assign CORE_INIT.wdt_enable = 1'b1;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // checker helper: cycles since an outside party last pulled the pin low
   logic [3:0] pin_hi_cnt;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pin_hi_cnt <= 4'hf;
      end else if (!RST_PIN_I && !RST_PIN_OE) begin
         pin_hi_cnt <= 4'h0;
      end else if (pin_hi_cnt != 4'hf) begin
         pin_hi_cnt <= pin_hi_cnt + 4'h1;
      end
   end

   a_pin_hold: assert property (@(posedge CLK) disable iff (!RESETN)
      pin_hi_cnt < 4'(PIN_HOLD_CYC) |-> CORE_RESET)
      else $error("pin reset released too early");
   a_pin_release: assert property (@(posedge CLK) disable iff (!RESETN)
      r.phase == ST_RUN |-> !RST_PIN_OE)
      else $error("reset pin still driven while running");
   a_mcd_no_pin: assert property (@(posedge CLK) disable iff (!RESETN)
      (mcd_src && !RST_PIN_OE && !por_src) |=> !RST_PIN_OE)
      else $error("clock detector reset drove the pin");
   a_cmp_no_pin: assert property (@(posedge CLK) disable iff (!RESETN)
      (cmp_src && !RST_PIN_OE && !por_src) |=> !RST_PIN_OE)
      else $error("comparator reset drove the pin");
   a_cnv_no_pin: assert property (@(posedge CLK) disable iff (!RESETN)
      (cnv_src && !RST_PIN_OE && !por_src) |=> !RST_PIN_OE)
      else $error("convert input reset drove the pin");
   a_arm_clear: assert property (@(posedge CLK) disable iff (!RESETN)
      $rose(r.phase == ST_RUN) |-> (!r.cmp_arm && !r.cnv_arm))
      else $error("reset source arms survived reset");
   a_rdata_idle: assert property (@(posedge CLK) disable iff (!RESETN)
      !$past(RD) |-> RDATA == 8'h00)
      else $error("read data outside read cycle");
   a_init_const: assert property (@(posedge CLK) disable iff (!RESETN)
      CORE_INIT.pc_load == PC_RESET && CORE_INIT.wdt_enable)
      else $error("core start values wrong");
   a_por_pin_drive: assert property (@(posedge CLK) disable iff (!RESETN)
      por_src |=> RST_PIN_OE)
      else $error("reset pin not driven on power reset");
   a_sw_no_pin: assert property (@(posedge CLK) disable iff (!RESETN)
      (sw_wr && !RST_PIN_OE && !por_src) |=> !RST_PIN_OE)
      else $error("software reset drove the pin");
   a_src_reset: assert property (@(posedge CLK) disable iff (!RESETN)
      any_src |=> CORE_RESET)
      else $error("source did not reset core");
   a_cmp_async: assert property (@(posedge CLK) disable iff (!RESETN)
      cmp_src |-> CORE_RESET)
      else $error("comparator reset not immediate");
   a_por_flag: assert property (@(posedge CLK) disable iff (!RESETN)
      (r.phase != ST_RUN && r.cause[BIT_POR]) ##1 r.phase == ST_RUN
      |-> r.flags == 7'h02)
      else $error("power flag wrong after power reset");
   a_wdt_flag: assert property (@(posedge CLK) disable iff (!RESETN)
      (r.phase != ST_RUN && !r.cause[BIT_POR]) ##1 r.phase == ST_RUN
      |-> r.flags[BIT_WDT] == $past(r.cause[BIT_WDT]))
      else $error("watchdog flag wrong");
   a_mcd_enable: assert property (@(posedge CLK) disable iff (!RESETN)
      !r.osc[BIT_MCD_EN] |-> !mcd_src)
      else $error("clock detector active while off");
   a_release_clk: assert property (@(posedge CLK) disable iff (!RESETN)
      $rose(r.phase == ST_RUN) |-> r.osc == 8'h00)
      else $error("clock select not reset");
   c_pin: cover property (@(posedge CLK) !RST_PIN_I ##[1:20] !CORE_RESET);
   c_sw: cover property (@(posedge CLK) sw_wr ##[1:30] r.flags[BIT_SW]);
   c_cmp: cover property (@(posedge CLK) cmp_src ##[1:30] r.flags[BIT_CMP]);
   c_wdt: cover property (@(posedge CLK) WDT_TIMEOUT ##[1:30] r.flags[BIT_WDT]);
endmodule : rst_source_ctl

`default_nettype wire

/* File: verilog/rstctl_pkg.sv */
// package: constants and carriers for the reset source controller
package rstctl_pkg;
   // ---------------------------------------------------------------
   // register map (byte offsets on the plain register port)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_SOURCE = 8'hef;
   localparam logic [7:0] ADDR_OSC = 8'hb2;
   localparam logic [7:0] ADDR_WDOG = 8'hff;
   // reset source register bit positions
   localparam int BIT_PIN = 0;
   localparam int BIT_POR = 1;
   localparam int BIT_MCD = 2;
   localparam int BIT_WDT = 3;
   localparam int BIT_SW = 4;
   localparam int BIT_CMP = 5;
   localparam int BIT_CNV = 6;
   // oscillator control register fields
   localparam int BIT_MCD_EN = 7;
   localparam logic [1:0] OSC_SEL_INT2M = 2'h0;
   // watchdog interval and core reset values
   localparam logic [2:0] WDT_INTERVAL_MAX = 3'h7;
   localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
   localparam logic [15:0] PC_RESET = 16'h0000;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int POR_TIMEOUT_MS = 100;
   localparam int POR_TIMEOUT_CYC = POR_TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int PIN_HOLD_CYC = 12;
   localparam int MCD_TIMEOUT_US = 100;
   localparam int MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * CLK_MHZ;
   localparam int CNT_W = 23;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_HOLD = 2'b01,
      ST_STRETCH = 2'b10
   } phase_e;

   typedef struct packed {
      logic [7:0] port_latch;
      logic [15:0] pc_load;
      logic [1:0] clk_sel;
      logic [2:0] wdt_interval;
      logic wdt_enable;
   } core_init_s;
endpackage : rstctl_pkg

/* File: dv/rst_env_model.sv */
// far-side model: supply monitor, reset pin, comparator and clock sources
`timescale 1ns/10ps
`default_nettype none

module rst_env_model (
   // scenario requests from the bench
   input wire logic ext_low,
   input wire logic sup_low,
   input wire logic cmp_low,
   input wire logic cnv_low,
   input wire logic clk_dead,
   input wire logic wdt_fire,
   // open-drain drive of the reset pin by the block
   input wire logic pin_o,
   input wire logic pin_oe,
   // source levels seen by the block
   output logic supply_low,
   output logic rst_pin,
   output logic cmp_out,
   output logic cnv_in,
   output logic alive,
   output logic wdt_pulse
);
   // ---------------------------------------------------------------
   // source levels
   // ---------------------------------------------------------------
   // pin has a pull-up: low only while some party pulls it
   assign rst_pin = !(ext_low || (pin_oe && !pin_o));
   assign supply_low = sup_low;
   // comparator is enabled and settled long before it is armed
   assign cmp_out = !cmp_low;
   // convert input already routed to a pin, idles high
   assign cnv_in = !cnv_low;
   assign alive = !clk_dead;
   assign wdt_pulse = wdt_fire;
endmodule : rst_env_model

`default_nettype wire

/* File: dv/tb_top.sv */
// testbench: drives every reset source, checks release timing and flags
`timescale 1ns/10ps
`default_nettype none

module tb_top
   import rstctl_pkg::*;
;
   localparam int POR_C = 50;
   localparam int MCD_C = 20;
   localparam core_init_s INIT_EXP = '{port_latch: PORT_LATCH_RESET,
      pc_load: PC_RESET, clk_sel: OSC_SEL_INT2M,
      wdt_interval: WDT_INTERVAL_MAX, wdt_enable: 1'b1};
   logic clk, resetn, wr, rd, ext_low, sup_low, cmp_low, cnv_low;
   logic clk_dead, wdt_fire, supply_low, rst_pin, cmp_out, cnv_in;
   logic alive, wdt_pulse, pin_o, pin_oe, core_reset, core_async;
   logic [7:0] addr, wdata, rdata;
   core_init_s core_init;
   int err_total, checks;

   rst_source_ctl #(.POR_CYCLES(POR_C), .MCD_CYCLES(MCD_C)) DUT (
      .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .SUPPLY_LOW(supply_low), .RST_PIN_I(rst_pin),
      .CONVERT_START_INPUT(cnv_in), .COMPARATOR_OUT(cmp_out),
      .CLOCK_ALIVE(alive), .WDT_TIMEOUT(wdt_pulse), .RST_PIN_O(pin_o),
      .RST_PIN_OE(pin_oe), .CORE_RESET(core_reset),
      .CORE_RESET_ASYNC(core_async), .CORE_INIT(core_init));

   rst_env_model partner (
      .ext_low(ext_low), .sup_low(sup_low), .cmp_low(cmp_low),
      .cnv_low(cnv_low), .clk_dead(clk_dead), .wdt_fire(wdt_fire),
      .pin_o(pin_o), .pin_oe(pin_oe), .supply_low(supply_low),
      .rst_pin(rst_pin), .cmp_out(cmp_out), .cnv_in(cnv_in),
      .alive(alive), .wdt_pulse(wdt_pulse));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   // bounded wait for the core reset level; n counts the cycles
   task automatic wait_lvl(input logic lvl, output int n);
      n = 0;
      while (core_reset !== lvl) begin
         @(posedge clk);
         #1 n++;
         if (n > 200) begin
            err_total++;
            results();
         end
      end
   endtask : wait_lvl

   // sources are dropped three cycles after reset is seen, so level sources stretch
   task automatic run_src(input logic [7:0] fl, input logic oe,
         input int lo, input string name);
      int n;
      logic [7:0] v;
      wait_lvl(1'b1, n);
      repeat (2) @(posedge clk);
      #1 chk(pin_oe, oe);
      @(posedge clk);
      {ext_low, sup_low, cmp_low, cnv_low, clk_dead, wdt_fire} <= 6'h00;
      wait_lvl(1'b0, n);
      chk(n >= lo && n <= lo + 8, 1'b1);
      chk(pin_oe, 1'b0);
      chk(core_init, INIT_EXP);
      rd_reg(ADDR_SOURCE, v);
      chk(v, fl);
      $display("test %s done", name);
   endtask : run_src

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_armed(input logic [7:0] arm, input string name);
      @(posedge clk);
      cmp_low <= arm[5];
      cnv_low <= arm[6];
      repeat (4) @(posedge clk);
      #1 chk(core_reset, 1'b0);
      @(posedge clk);
      cmp_low <= 1'b0;
      cnv_low <= 1'b0;
      wr_reg(ADDR_SOURCE, arm);
      @(posedge clk);
      cmp_low <= arm[5];
      cnv_low <= arm[6];
      #1 chk(core_async, arm[5]);
      run_src(arm, 1'b0, 12, name);
   endtask : t_armed

   task automatic t_mcd();
      logic [7:0] v;
      @(posedge clk);
      clk_dead <= 1'b1;
      repeat (MCD_C * 2) @(posedge clk);
      #1 chk(core_reset, 1'b0);
      wr_reg(ADDR_OSC, 8'h80);
      rd_reg(ADDR_OSC, v);
      chk(v, 8'h80);
      run_src(8'h04, 1'b0, 12, "mcd");
      rd_reg(ADDR_OSC, v);
      chk(v, 8'h00);
   endtask : t_mcd

   task automatic results();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      int n;
      logic [7:0] v;
      resetn = 1'b0;
      {addr, wdata, wr, rd} = '0;
      {ext_low, sup_low, cmp_low, cnv_low, clk_dead, wdt_fire} = '0;
      err_total = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      #1 chk(core_reset, 1'b1);
      chk(pin_oe, 1'b1);
      chk(core_init, INIT_EXP);
      @(posedge clk);
      resetn <= 1'b1;
      wait_lvl(1'b0, n);
      rd_reg(ADDR_SOURCE, v);
      chk(v, 8'h02);
      @(posedge clk);
      ext_low <= 1'b1;
      run_src(8'h01, 1'b0, 12, "pin");
      @(posedge clk);
      wdt_fire <= 1'b1;
      run_src(8'h08, 1'b0, 12, "wdt");
      wr_reg(ADDR_SOURCE, 8'h10);
      run_src(8'h10, 1'b0, 6, "sw");
      wr_reg(ADDR_SOURCE, 8'h02);
      run_src(8'h02, 1'b1, POR_C - 6, "por");
      @(posedge clk);
      sup_low <= 1'b1;
      run_src(8'h02, 1'b1, POR_C, "supply");
      t_armed(8'h20, "cmp");
      t_armed(8'h40, "cnv");
      t_mcd();
      results();
   end
endmodule : tb_top

`default_nettype wire
